// *** hw/panel_scan_pkg.sv ***
`default_nettype none
package panel_scan_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned PHASE_HZ = 640;
  // half-phase of the latch enable clock, rounded down
  // a full period here would outlast the refresh interval and starve the second latch
  localparam int unsigned PHASE_CYCLES = CLK_HZ / (2 * PHASE_HZ);
  // refresh interval in ns, as printed: 1.56 ms
  localparam int unsigned REFRESH_NS = 1560000;
  localparam int unsigned REFRESH_CYCLES = REFRESH_NS / 8;
  // blanking guard around select changes
  localparam int unsigned GUARD_CYCLES = 16;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int unsigned SEG_W = 16;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned LINES = 8;
  localparam int unsigned COL_W = 3;
  localparam int unsigned DAC_W = 12;
  localparam logic [SEG_W-1:0] SEG_RESET = 16'h0000;
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h2;
  localparam logic [DAC_W-1:0] DAC_RESET = 12'h800;
  // code that lights the first readout position
  localparam logic [SEL_W-1:0] FIRST_READOUT_CODE = 3'h2;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [SEG_W-1:0] first;
    logic [SEG_W-1:0] second;
  } seg_pair_t;

  typedef struct packed {
    logic [DAC_W-1:0] volt;
    logic [DAC_W-1:0] cap;
  } dac_pair_t;

  typedef enum logic [1:0] {ST_BLANK, ST_FIRST, ST_GAP, ST_SECOND} phase_t;

endpackage
`default_nettype wire

// *** hw/panel_scan.sv ***
// Behaviour
// R1 - one refresh step, servicing the next digit pair, every 1.56 ms
// R2 - only the 640 Hz phase clock decides when latch outputs drive segments; here each refresh write also restarts the phase sequence
// R3 - processor writes two digit patterns, one per latch, each interrupt
// R4 - latch outputs enabled one after the other, never together
// R5 - enabled pattern drives segments only in the selected digit
// R6 - three-bit code drives exactly one active-low digit select low
// R7 - select code 010 enables the first readout position
// R8 - annunciator groups use the same select path and latch patterns
// R9 - row decoder drives exactly one addressed row high
// R10 - column inputs read high for closed switch, low for open
// R11 - two independent converter channels, voltage and capacitance or current
// R12 - each converter channel holds a 12-bit split code
// R13 - segments blanked while the select code changes
`timescale 1ns/1ns
`default_nettype none
module panel_scan
  import panel_scan_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // processor side: segment patterns and select code
  input wire logic refresh_wr,
  input wire seg_pair_t seg_pair_in,
  input wire logic [SEL_W-1:0] select_code_in,
  output logic refresh_irq,
  // keypad matrix
  input wire logic key_column_in0,
  input wire logic key_column_in1,
  input wire logic key_column_in2,
  output logic [COL_W-1:0] key_columns,
  output logic [LINES-1:0] key_rows,
  // display drive
  output logic [LINES-1:0] digit_select_n,
  output logic [SEG_W-1:0] segments,
  output logic latch_first_en,
  output logic latch_second_en,
  // converter channels
  input wire logic dac_wr,
  input wire dac_pair_t dac_in,
  output dac_pair_t dac_out
);

  // ****************************************
  // helpers
  // ****************************************
  // one-hot decode used by both the digit and row decoders
  function automatic logic [LINES-1:0] one_hot(input logic [SEL_W-1:0] c);
    logic [LINES-1:0] v;
    v = '0;
    v[c] = 1'b1;
    return v;
  endfunction

  // ****************************************
  // refresh timer
  // ****************************************
  logic [31:0] refresh_cnt_r;
  logic [31:0] phase_cnt_r;
  logic [SEL_W-1:0] sel_r;
  seg_pair_t seg_latch_r;
  phase_t phase_r;

  // R1 refresh interval tick
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      refresh_cnt_r <= '0;
      refresh_irq <= 1'b0;
    end
    else
    begin
      refresh_irq <= 1'b0;
      if (refresh_cnt_r == REFRESH_CYCLES - 1)
      begin
        refresh_cnt_r <= '0;
        refresh_irq <= 1'b1;
      end
      else
        refresh_cnt_r <= refresh_cnt_r + 32'd1;
    end
  end

  // ****************************************
  // segment latches and select code
  // ****************************************
  // R3 two patterns per write
  // select code taken on every write, and the same write blanks the segments so a digit never shows a stale pattern
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      seg_latch_r <= '{first: SEG_RESET, second: SEG_RESET};
      sel_r <= SEL_RESET;
    end
    else if (refresh_wr)
    begin
      seg_latch_r <= seg_pair_in;
      sel_r <= select_code_in;
    end
  end

  // ****************************************
  // 640 Hz phase sequencer
  // ****************************************
  // R2 phase clock paces enables, restarted from blank by each write
  // R4 first then second, guard gap between
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      phase_r <= ST_BLANK;
      phase_cnt_r <= '0;
    end
    else if (refresh_wr)
    begin
      // R13 blank on select change
      phase_r <= ST_BLANK;
      phase_cnt_r <= '0;
    end
    else
    begin
      phase_cnt_r <= phase_cnt_r + 32'd1;
      case (phase_r)
        ST_BLANK:
        begin
          if (phase_cnt_r >= GUARD_CYCLES - 1)
          begin
            phase_r <= ST_FIRST;
            phase_cnt_r <= '0;
          end
        end
        ST_FIRST:
        begin
          if (phase_cnt_r >= PHASE_CYCLES - 1)
          begin
            phase_r <= ST_GAP;
            phase_cnt_r <= '0;
          end
        end
        ST_GAP:
        begin
          if (phase_cnt_r >= GUARD_CYCLES - 1)
          begin
            phase_r <= ST_SECOND;
            phase_cnt_r <= '0;
          end
        end
        ST_SECOND:
        begin
          if (phase_cnt_r >= PHASE_CYCLES - 1)
          begin
            phase_r <= ST_GAP;
            phase_cnt_r <= '0;
          end
        end
        default:
          phase_r <= ST_BLANK;
      endcase
    end
  end

  // ****************************************
  // display and row outputs
  // ****************************************
  // R5 R6 R7 R8 decoded select with pattern
  // R9 row decode shares the select code
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      digit_select_n <= '1;
      key_rows <= '0;
      segments <= '0;
      latch_first_en <= 1'b0;
      latch_second_en <= 1'b0;
    end
    else
    begin
      // R6 one low output
      digit_select_n <= ~one_hot(sel_r);
      // R9 one high row
      key_rows <= one_hot(sel_r);
      latch_first_en <= (phase_r == ST_FIRST) && !refresh_wr;
      latch_second_en <= (phase_r == ST_SECOND) && !refresh_wr;
      // R13 blank on change
      if (refresh_wr)
        segments <= '0;
      else if (phase_r == ST_FIRST)
        segments <= seg_latch_r.first;
      else if (phase_r == ST_SECOND)
        segments <= seg_latch_r.second;
      else
        segments <= '0;
    end
  end

  // ****************************************
  // keypad columns
  // ****************************************
  // R10 closed reads high
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      key_columns <= '0;
    else
      key_columns <= {key_column_in2, key_column_in1, key_column_in0};
  end

  // ****************************************
  // converter channels
  // ****************************************
  // R11 R12 two held 12-bit codes
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      dac_out <= '{volt: DAC_RESET, cap: DAC_RESET};
    else if (dac_wr)
      dac_out <= dac_in;
  end

endmodule
`default_nettype wire

// *** tb/panel_scan_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module panel_scan_props
  import panel_scan_pkg::*;
(
  // all ports of the scanner
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic refresh_wr,
  input wire seg_pair_t seg_pair_in,
  input wire logic [SEL_W-1:0] select_code_in,
  input wire logic refresh_irq,
  input wire logic key_column_in0,
  input wire logic key_column_in1,
  input wire logic key_column_in2,
  input wire logic [COL_W-1:0] key_columns,
  input wire logic [LINES-1:0] key_rows,
  input wire logic [LINES-1:0] digit_select_n,
  input wire logic [SEG_W-1:0] segments,
  input wire logic latch_first_en,
  input wire logic latch_second_en,
  input wire logic dac_wr,
  input wire dac_pair_t dac_in,
  input wire dac_pair_t dac_out
);
  // ****************************************
  // one clock domain throughout
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire logic any_en = latch_first_en | latch_second_en;
  en_excl_a: assert property (!(latch_first_en && latch_second_en))
    else $error("both latch enables high");
  sel_cold_a: assert property (!$past(sys_rst) |-> $onehot(~digit_select_n))
    else $error("digit select not one-cold");
  row_hot_a: assert property (!$past(sys_rst) |-> $onehot(key_rows))
    else $error("key rows not one-hot");
  row_match_a: assert property (key_rows == ~digit_select_n)
    else $error("row and digit select disagree");
  blank_wr_a: assert property (refresh_wr |=> segments == '0 && !any_en)
    else $error("segments not blanked after write");
  sel_load_a: assert property (refresh_wr |-> ##2
    digit_select_n == ~(8'h01 << $past(select_code_in, 2)))
    else $error("digit select does not follow code");
  seg_dark_a: assert property (!any_en |-> segments == '0)
    else $error("segments lit with no latch enabled");
  sel_still_a: assert property (any_en |-> $stable(digit_select_n))
    else $error("select moved while segments lit");
  col_copy_a: assert property (!$past(sys_rst) |->
    key_columns == $past({key_column_in2, key_column_in1, key_column_in0}))
    else $error("column readback wrong");
  dac_hold_a: assert property (dac_wr |=> dac_out == $past(dac_in))
    else $error("converter codes not loaded");
  irq_pulse_a: assert property (refresh_irq |=> !refresh_irq)
    else $error("refresh pulse too long");
endmodule
bind panel_scan panel_scan_props i_panel_scan_props (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .refresh_wr(refresh_wr),
  .seg_pair_in(seg_pair_in), .select_code_in(select_code_in), .refresh_irq(refresh_irq),
  .key_column_in0(key_column_in0), .key_column_in1(key_column_in1),
  .key_column_in2(key_column_in2), .key_columns(key_columns), .key_rows(key_rows),
  .digit_select_n(digit_select_n), .segments(segments), .latch_first_en(latch_first_en),
  .latch_second_en(latch_second_en), .dac_wr(dac_wr), .dac_in(dac_in), .dac_out(dac_out));
`default_nettype wire

// *** tb/key_matrix.sv ***
`timescale 1ns/1ns
`default_nettype none
module key_matrix
  import panel_scan_pkg::*;
(
  // row drive and closed-switch map, three columns a row
  input wire logic [LINES-1:0] key_rows,
  input wire logic [3*LINES-1:0] closed,
  // column lines, pulled low when open
  output logic key_column_in0,
  output logic key_column_in1,
  output logic key_column_in2
);
  always_comb
  begin
    logic [2:0] cols;
    cols = 3'h0;
    for (int r = 0; r < LINES; r++)
      if (key_rows[r] === 1'b1)
        cols = cols | closed[r*3 +: 3];
    {key_column_in2, key_column_in1, key_column_in0} = cols;
  end
endmodule
`default_nettype wire

// *** tb/panel_scan_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module panel_scan_tb_top;
  import panel_scan_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic refresh_wr = 1'b0;
  logic dac_wr = 1'b0;
  seg_pair_t seg_pair_in = '0;
  dac_pair_t dac_in = '0;
  dac_pair_t dac_out;
  logic [SEL_W-1:0] select_code_in = '0;
  logic [23:0] closed = 24'h5ca396;
  logic c0, c1, c2, refresh_irq, latch_first_en, latch_second_en;
  logic [COL_W-1:0] key_columns;
  logic [LINES-1:0] key_rows, digit_select_n;
  logic [SEG_W-1:0] segments;
  int errors = 0;
  int checks_done = 0;
  always #4 sys_clk = ~sys_clk;
  panel_scan i_panel_scan (.sys_clk(sys_clk), .sys_rst(sys_rst), .refresh_wr(refresh_wr),
    .seg_pair_in(seg_pair_in), .select_code_in(select_code_in), .refresh_irq(refresh_irq),
    .key_column_in0(c0), .key_column_in1(c1), .key_column_in2(c2), .key_columns(key_columns),
    .key_rows(key_rows), .digit_select_n(digit_select_n), .segments(segments),
    .latch_first_en(latch_first_en), .latch_second_en(latch_second_en), .dac_wr(dac_wr),
    .dac_in(dac_in), .dac_out(dac_out));
  key_matrix i_key_matrix (.key_rows(key_rows), .closed(closed), .key_column_in0(c0),
    .key_column_in1(c1), .key_column_in2(c2));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // load a pair and code, then follow blanking into the first phase
  task automatic show(input logic [2:0] code, input logic [15:0] pat);
    int n;
    n = 0;
    refresh_wr = 1'b1;
    select_code_in = code;
    seg_pair_in = {pat, ~pat};
    @(negedge sys_clk);
    refresh_wr = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("blank", {segments, 14'h0, latch_first_en, latch_second_en}, 32'h0);
    check("digit", digit_select_n, ~(32'h1 << code) & 32'hff);
    check("row", key_rows, 32'h1 << code);
    check("cols", key_columns, closed[code*3 +: 3]);
    while (latch_first_en !== 1'b1 && n < 40)
    begin
      @(negedge sys_clk);
      n++;
    end
    check("first", {segments, 14'h0, latch_first_en, latch_second_en}, {pat, 16'h2});
  endtask
  // hold the first phase to its end, then cross the gap into the second
  task automatic hand_over(input logic [15:0] pat);
    repeat (PHASE_CYCLES - 1) @(negedge sys_clk);
    check("first held", {segments, 15'h0, latch_first_en}, {pat, 16'h1});
    @(negedge sys_clk);
    check("gap", {segments, 14'h0, latch_first_en, latch_second_en}, 32'h0);
    check("no irq", refresh_irq, 32'h0);
    repeat (GUARD_CYCLES - 1) @(negedge sys_clk);
    check("gap end", latch_second_en, 32'h0);
    @(negedge sys_clk);
    check("second", {segments, 14'h0, latch_first_en, latch_second_en}, {~pat, 16'h1});
  endtask
  // converter codes; input moves off the write to prove the hold
  task automatic dac_load(input logic [23:0] v);
    dac_wr = 1'b1;
    dac_in = v;
    @(negedge sys_clk);
    dac_wr = 1'b0;
    dac_in = ~v;
    @(negedge sys_clk);
    check("dac", dac_out, v);
  endtask
  initial
  begin
    repeat (2) @(negedge sys_clk);
    check("rst", {digit_select_n, segments, latch_first_en, refresh_irq}, {6'h0, 8'hff, 18'h0});
    check("rst rows", {key_rows, key_columns}, 32'h0);
    check("rst dac", dac_out, 24'h800800);
    sys_rst = 1'b0;
    @(negedge sys_clk);
    check("code 010", digit_select_n, ~(32'h1 << FIRST_READOUT_CODE) & 32'hff);
    for (int k = 0; k < 8; k++)
      show(3'(k), 16'(k * 16'h1111 + 16'h0f0f));
    hand_over(16'(7 * 16'h1111 + 16'h0f0f));
    dac_load(24'h000fff);
    dac_load(24'hfff000);
    summarize();
  end
  // hang guard: one latch phase plus slack for the short scenarios
  initial
  begin
    #((PHASE_CYCLES + 1000) * 8);
    errors++;
    summarize();
  end
endmodule
`default_nettype wire
